// ---- logic/io_map_cfg.svh ----
// io_map_cfg.svh: base addresses, window sizes and limits of the io space
// assumes a 16-bit byte address and an 8-bit data bus
`ifndef IO_MAP_CFG_SVH
`define IO_MAP_CFG_SVH

// peripheral bases
`define BASE_VIRTUAL_PINS_A   16'h0000
`define BASE_VIRTUAL_PINS_B   16'h0004
`define BASE_VIRTUAL_PINS_C   16'h0008
`define BASE_GENERAL_PURPOSE  16'h001C
`define BASE_CORE_REGS        16'h0030
`define BASE_RESET_CONTROLLER 16'h0040
`define BASE_PIN_GROUP_A      16'h0400
`define BASE_PIN_GROUP_B      16'h0420
`define BASE_PIN_GROUP_C      16'h0440
`define BASE_SERIAL_1         16'h0820
`define BASE_TWO_WIRE         16'h08A0
`define BASE_SERIAL_PERIPH    16'h08C0
`define BASE_TIMER_A          16'h0A00
`define BASE_TIMER_B_FIRST    16'h0A80
`define BASE_TIMER_B_SECOND   16'h0A90
`define BASE_SYSTEM_CONFIG    16'h0F00
`define BASE_NVM_CONTROLLER   16'h1000
// system memory bases
`define BASE_SIGNATURE        16'h1100
`define BASE_CONFIG_BITS      16'h1280
`define BASE_LOCK_BITS        16'h128A

// window sizes in bytes
`define SIZE_VIRTUAL_PINS     16'h0004
`define SIZE_SMALL_BLOCK      16'h0010
`define SIZE_PIN_GROUP        16'h0020
`define SIZE_TIMER_A          16'h0080
`define SIZE_PAGE             16'h0100
`define SIZE_CONFIG_BITS      16'h000A
`define SIZE_LOCK_BITS        16'h0001

// access limits and widths
`define NUM_REGIONS           20
`define SINGLE_CYCLE_LAST     16'h003F
`define BIT_ACCESS_LAST       16'h001F
`define WIDTH_8               2'h0
`define WIDTH_16              2'h1
`define WIDTH_32              2'h3

`endif

// ---- logic/io_bridge_pkg.sv ----
// io_bridge_pkg.sv: types shared by the bridge, the bus master and decoder
// assumes io_map_cfg.svh is on the include path
package io_bridge_pkg;
  `include "io_map_cfg.svh"

  typedef enum logic [4:0] {
    RG_VPA = 5'b00000, RG_VPB = 5'b00001, RG_VPC = 5'b00010,
    RG_GPR = 5'b00011, RG_CPU = 5'b00100, RG_RST = 5'b00101,
    RG_PGA = 5'b00110, RG_PGB = 5'b00111, RG_PGC = 5'b01000,
    RG_SR1 = 5'b01001, RG_TWU = 5'b01010, RG_SPU = 5'b01011,
    RG_TMA = 5'b01100, RG_TB0 = 5'b01101, RG_TB1 = 5'b01110,
    RG_SYS = 5'b01111, RG_NVM = 5'b10000, RG_SIG = 5'b10001,
    RG_CFG = 5'b10010, RG_LCK = 5'b10011, RG_NONE = 5'b11111
  } region_e;

  typedef enum logic [2:0] {
    BIT_NONE                  = 3'b000,
    BIT_SET_INSTRUCTION       = 3'b001,
    BIT_CLEAR_INSTRUCTION     = 3'b010,
    SKIP_IF_SET_INSTRUCTION   = 3'b011,
    SKIP_IF_CLEAR_INSTRUCTION = 3'b100
  } bit_op_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_ISSUE = 2'b01, HS_WAIT = 2'b10, HS_DONE = 2'b11
  } host_state_e;

  typedef logic [2:0][7:0] stage_t;

  typedef struct packed {
    stage_t [`NUM_REGIONS-1:0] stage;
    logic [7:0]                rdata;
    logic                      rvalid;
    logic                      skip;
    logic                      err;
    logic                      p_wr;
    region_e                   p_wsel;
    logic [7:0]                p_woff;
    logic [31:0]               p_wdata;
    logic [3:0]                p_wbe;
  } dev_state_s;

  typedef struct packed {
    host_state_e st;
    logic [15:0] addr;
    logic [1:0]  width;
    logic [1:0]  idx;
    logic        write;
    logic        port;
    bit_op_e     bit_op;
    logic [2:0]  bit_sel;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        skip;
    logic        err;
  } host_s;
endpackage

// ---- logic/io_bus_if.sv ----
// io_bus_if.sv: 8-bit core data bus between bus master and io bridge
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface io_bus_if;
  import io_bridge_pkg::*;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        port_op;
  bit_op_e     bit_op;
  logic [2:0]  bit_sel;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        skip;
  logic        err;
  modport device (input addr, wdata, wr, rd, port_op, bit_op, bit_sel,
                  output rdata, rvalid, skip, err);
  modport host (output addr, wdata, wr, rd, port_op, bit_op, bit_sel,
                input rdata, rvalid, skip, err);
endinterface

// ---- logic/addr_decoder.sv ----
// addr_decoder.sv: maps a byte address onto a peripheral window
// assumes windows never overlap; unmapped addresses give RG_NONE
`timescale 1ns/1ns
`include "io_map_cfg.svh"
module addr_decoder import io_bridge_pkg::*; (
  // address in
  input  wire logic [15:0] addr,
  // decode out
  output region_e          sel,
  output logic [7:0]       off,
  output logic             in_single,
  output logic             in_bit
);
  localparam logic [15:0] BASE [`NUM_REGIONS] = '{
    `BASE_VIRTUAL_PINS_A, `BASE_VIRTUAL_PINS_B,
    `BASE_VIRTUAL_PINS_C, `BASE_GENERAL_PURPOSE,
    `BASE_CORE_REGS, `BASE_RESET_CONTROLLER,
    `BASE_PIN_GROUP_A, `BASE_PIN_GROUP_B, `BASE_PIN_GROUP_C,
    `BASE_SERIAL_1, `BASE_TWO_WIRE, `BASE_SERIAL_PERIPH,
    `BASE_TIMER_A, `BASE_TIMER_B_FIRST, `BASE_TIMER_B_SECOND,
    `BASE_SYSTEM_CONFIG, `BASE_NVM_CONTROLLER,
    `BASE_SIGNATURE, `BASE_CONFIG_BITS, `BASE_LOCK_BITS};
  localparam logic [15:0] SIZE [`NUM_REGIONS] = '{
    `SIZE_VIRTUAL_PINS, `SIZE_VIRTUAL_PINS, `SIZE_VIRTUAL_PINS,
    `SIZE_VIRTUAL_PINS, `SIZE_SMALL_BLOCK, `SIZE_SMALL_BLOCK,
    `SIZE_PIN_GROUP, `SIZE_PIN_GROUP, `SIZE_PIN_GROUP,
    `SIZE_PIN_GROUP, `SIZE_PIN_GROUP, `SIZE_PIN_GROUP,
    `SIZE_TIMER_A, `SIZE_SMALL_BLOCK, `SIZE_SMALL_BLOCK,
    `SIZE_PAGE, `SIZE_PAGE, `SIZE_TIMER_A,
    `SIZE_CONFIG_BITS, `SIZE_LOCK_BITS};

  // window test, shared by every table entry
  function automatic logic in_window(input logic [15:0] a,
                                     input logic [15:0] b,
                                     input logic [15:0] s);
    in_window = (a >= b) && ((a - b) < s);
  endfunction

  // first matching window wins; table order is ascending
  always_comb begin
    sel = RG_NONE;
    off = 8'h00;
    for (int i = 0; i < `NUM_REGIONS; i++) begin
      if (sel == RG_NONE && in_window(addr, BASE[i], SIZE[i])) begin
        sel = region_e'(5'(i));
        off = 8'(addr - BASE[i]);
      end
    end
  end

  // low windows reachable by the short instruction forms
  assign in_single = (addr <= `SINGLE_CYCLE_LAST);
  assign in_bit    = (addr <= `BIT_ACCESS_LAST);
endmodule

// ---- logic/io_bridge.sv ----
// io_bridge.sv: device end, 8-bit core bus to the peripheral register space
// assumes peripherals answer p_width and p_live combinationally
// the peripherals sit outside; only their staging bytes live here
// one staging set per region keeps wide accesses of peripherals apart
// limitation: bit operations treat every register as 8-bit
//
// Overview of operation
// - wide registers reached only through staging bytes
// - low byte write loads staging, not register
// - high byte write commits staged low byte
// - master writes low byte before high byte
// - low byte read captures high byte into staging
// - high byte read returns staging byte
// - master reads low byte before high byte
// - 32-bit uses three staging bytes likewise
// - master keeps multi-byte access uninterrupted
// - short port instructions reach 0x00 to 0x3F
// - bit set/clear/skip for 0x00 to 0x1F
// - reserved bits written as zero
// - master never writes unmapped addresses
// - general purpose, core, reset controller bases
// - pin group config bases A, B, C
// - serial, two-wire, serial peripheral bases
// - timer type A and two type B bases
// - system config and nvm controller bases
// - signature, config bits, lock bits bases
`timescale 1ns/1ns
`include "io_map_cfg.svh"
module io_bridge import io_bridge_pkg::*; (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // core bus
  io_bus_if.device         bus,
  // peripheral lookup
  output region_e          p_sel,
  output logic [7:0]       p_off,
  input  wire logic [1:0]  p_width,
  input  wire logic [31:0] p_live,
  // peripheral commit
  output logic             p_wr,
  output region_e          p_wsel,
  output logic [7:0]       p_woff,
  output logic [31:0]      p_wdata,
  output logic [3:0]       p_wbe
);
  // whole state, registered and next
  dev_state_s  q;
  dev_state_s  d;
  // decoder results for the current bus address
  region_e     sel;
  logic [7:0]  off;
  logic        in_single;
  logic        in_bit;
  // byte lane and staging slot of the current access
  logic [1:0]  k;
  logic [7:0]  aoff;
  logic [4:0]  ri;
  // request qualifiers
  logic        bad;
  logic        any;
  // byte under a bit operation, and its mask
  logic [7:0]  live_b;
  logic [7:0]  bit_m;

  // byte k of a wide value
  function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                           input logic [1:0]  i);
    pick_byte = w[8*i +: 8];
  endfunction

  // bytes below the top one come from staging
  function automatic logic [31:0] merge(input stage_t     s,
                                        input logic [7:0] top,
                                        input logic [1:0] i);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int j = 0; j < 3; j++) begin
      w[8*j +: 8] = s[j];
    end
    w[8*i +: 8] = top;
    merge = w;
  endfunction

  // enables for every byte up to and including the top one
  function automatic logic [3:0] lanes(input logic [1:0] i);
    case (i)
      2'h0:    lanes = 4'h1;
      2'h1:    lanes = 4'h3;
      2'h2:    lanes = 4'h7;
      default: lanes = 4'hF;
    endcase
  endfunction

  addr_decoder u_dec (
    .addr      (bus.addr),
    .sel       (sel),
    .off       (off),
    .in_single (in_single),
    .in_bit    (in_bit)
  );

  // byte position inside the addressed register, and its aligned offset
  assign k      = off[1:0] & p_width;
  assign aoff   = off & ~{6'h00, p_width};
  assign ri     = sel;
  assign p_sel  = sel;
  assign p_off  = aoff;
  assign live_b = pick_byte(p_live, k);
  assign bit_m  = 8'h01 << bus.bit_sel;

  // request legality: unmapped, or short form outside its window
  // refused requests leave every staging byte as it was
  assign any = bus.wr || bus.rd || (bus.bit_op != BIT_NONE);
  assign bad = (sel == RG_NONE) ||
               (bus.port_op && !in_single) ||
               ((bus.bit_op != BIT_NONE) && !in_bit);

  // one access per cycle; answers land one cycle later
  always_comb begin
    d        = q;
    // answers and commits are one-cycle pulses by default
    d.rdata  = 8'h00;
    d.rvalid = 1'b0;
    d.skip   = 1'b0;
    d.err    = 1'b0;
    d.p_wr   = 1'b0;
    if (any && bad) begin
      // write dropped, read answers zero
      d.err    = 1'b1;
      d.rvalid = bus.rd || (bus.bit_op == SKIP_IF_SET_INSTRUCTION) ||
                 (bus.bit_op == SKIP_IF_CLEAR_INSTRUCTION);
    end else if (bus.bit_op != BIT_NONE) begin
      // read-modify-write of one byte; skip forms only read
      case (bus.bit_op)
        BIT_SET_INSTRUCTION: begin
          d.p_wr    = 1'b1;
          d.p_wdata = {24'h00_0000, live_b | bit_m};
        end
        BIT_CLEAR_INSTRUCTION: begin
          d.p_wr    = 1'b1;
          d.p_wdata = {24'h00_0000, live_b & ~bit_m};
        end
        SKIP_IF_SET_INSTRUCTION: begin
          d.rvalid = 1'b1;
          d.rdata  = live_b;
          d.skip   = |(live_b & bit_m);
        end
        default: begin
          d.rvalid = 1'b1;
          d.rdata  = live_b;
          d.skip   = ~|(live_b & bit_m);
        end
      endcase
      d.p_wsel = sel;
      d.p_woff = aoff;
      d.p_wbe  = lanes(`WIDTH_8);
    end else if (bus.wr) begin
      if (k != p_width) begin
        // lower bytes only park in this instance's staging
        d.stage[ri][k] = bus.wdata;
      end else begin
        // top byte commits the whole register at once
        d.p_wr    = 1'b1;
        d.p_wsel  = sel;
        d.p_woff  = aoff;
        d.p_wdata = merge(q.stage[ri], bus.wdata, k);
        d.p_wbe   = lanes(k);
      end
    end else if (bus.rd) begin
      // low byte answers live and freezes the upper bytes
      d.rvalid = 1'b1;
      if (k == 2'h0) begin
        d.rdata = live_b;
        // plain 8-bit reads must not disturb a pending wide access
        if (p_width != `WIDTH_8) begin
          d.stage[ri] = p_live[31:8];
        end
      end else begin
        // upper bytes come from the frozen copy, never live
        d.rdata = q.stage[ri][k - 2'h1];
      end
    end
  end

  // whole state in one register
  // synchronous reset clears staging, answers and commits alike
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // answers and commits straight from flops
  // every answer lands exactly one cycle after its request
  assign bus.rdata  = q.rdata;
  assign bus.rvalid = q.rvalid;
  assign bus.skip   = q.skip;
  assign bus.err    = q.err;
  assign p_wr       = q.p_wr;
  assign p_wsel     = q.p_wsel;
  assign p_woff     = q.p_woff;
  assign p_wdata    = q.p_wdata;
  assign p_wbe      = q.p_wbe;
endmodule

// ---- logic/bus_master.sv ----
// bus_master.sv: core end, splits wide accesses into ordered byte cycles
// assumes cmd_addr is the low byte address of the register
`timescale 1ns/1ns
`include "io_map_cfg.svh"
module bus_master import io_bridge_pkg::*; (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_write,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [1:0]  cmd_width,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic [31:0] cmd_resv,
  input  wire logic        cmd_port,
  input  wire bit_op_e     cmd_bit_op,
  input  wire logic [2:0]  cmd_bit_sel,
  // response
  output logic             resp_valid,
  output logic [31:0]      resp_rdata,
  output logic             resp_skip,
  output logic             resp_err,
  // core bus
  io_bus_if.host           bus
);
  host_s   q;
  host_s   d;
  region_e csel;
  logic    is_store;

  addr_decoder u_dec (
    .addr      (cmd_addr),
    .sel       (csel),
    .off       (),
    .in_single (),
    .in_bit    ()
  );

  assign is_store = cmd_write || (cmd_bit_op == BIT_SET_INSTRUCTION) ||
                    (cmd_bit_op == BIT_CLEAR_INSTRUCTION);

  // accept, issue bytes low first, wait one cycle per byte for the answer
  always_comb begin
    d = q;
    case (q.st)
      HS_IDLE: begin
        if (cmd_valid) begin
          d.addr    = cmd_addr;
          d.write   = cmd_write;
          d.port    = cmd_port;
          d.bit_op  = cmd_bit_op;
          d.bit_sel = cmd_bit_sel;
          d.width   = (cmd_bit_op != BIT_NONE) ? `WIDTH_8 : cmd_width;
          d.wdata   = cmd_wdata & ~cmd_resv;
          d.rdata   = 32'h0000_0000;
          d.idx     = 2'h0;
          d.skip    = 1'b0;
          d.err     = 1'b0;
          if (is_store && csel == RG_NONE) begin
            d.err = 1'b1;
            d.st  = HS_DONE;
          end else begin
            d.st = HS_ISSUE;
          end
        end
      end
      HS_ISSUE: d.st = HS_WAIT;
      HS_WAIT: begin
        d.err  = q.err | bus.err;
        d.skip = q.skip | bus.skip;
        if (bus.rvalid) begin
          d.rdata[8*q.idx +: 8] = bus.rdata;
        end
        if (q.idx == q.width) begin
          d.st = HS_DONE;
        end else begin
          d.idx = q.idx + 2'h1;
          d.st  = HS_ISSUE;
        end
      end
      default: d.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // nothing else may use the bus until the last byte is answered
  assign cmd_ready   = (q.st == HS_IDLE);
  assign bus.addr    = q.addr + {14'h0000, q.idx};
  assign bus.wdata   = q.wdata[8*q.idx +: 8];
  assign bus.wr      = (q.st == HS_ISSUE) && q.write &&
                       (q.bit_op == BIT_NONE);
  assign bus.rd      = (q.st == HS_ISSUE) && !q.write &&
                       (q.bit_op == BIT_NONE);
  assign bus.port_op = (q.st == HS_ISSUE) && q.port;
  assign bus.bit_op  = (q.st == HS_ISSUE) ? q.bit_op : BIT_NONE;
  assign bus.bit_sel = q.bit_sel;
  assign resp_valid  = (q.st == HS_DONE);
  assign resp_rdata  = q.rdata;
  assign resp_skip   = q.skip;
  assign resp_err    = q.err;
endmodule

// ---- verification/io_bus_props.sv ----
// io_bus_props.sv: timing checks on the core bus between both ends
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module io_bus_props import io_bridge_pkg::*; (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // core bus
  input wire logic [15:0] addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        port_op,
  input wire bit_op_e     bit_op,
  input wire logic        rvalid,
  input wire logic        skip,
  input wire logic        err
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // two byte strobes of one wide access sit two cycles apart
  sequence rd_pair;
    rd ##2 rd;
  endsequence
  sequence wr_pair;
    wr ##2 wr;
  endsequence

  // bit-accessible places that are also mapped
  logic bit_ok;
  assign bit_ok = addr <= 16'h000B || (addr >= 16'h001C && addr <= 16'h001F);

  chk_rd_low_first: assert property (
    rd_pair |-> addr == $past(addr, 2) + 16'h0001)
    else $error("read bytes not in rising order");
  chk_wr_high_last: assert property (
    wr_pair |-> addr == $past(addr, 2) + 16'h0001)
    else $error("write bytes not in rising order");
  chk_strobe_gap: assert property (
    (wr || rd) |=> !(wr || rd))
    else $error("byte strobes back to back");
  chk_read_answer: assert property (
    rvalid == $past(rd || bit_op == SKIP_IF_SET_INSTRUCTION ||
                    bit_op == SKIP_IF_CLEAR_INSTRUCTION))
    else $error("read answer missing or spurious");
  chk_skip_answer: assert property (
    skip |-> rvalid)
    else $error("skip without read answer");
  chk_hole_refused: assert property (
    (wr || rd) && addr[15:13] != 3'h0 |=> err)
    else $error("unmapped access not refused");
  chk_port_range: assert property (
    port_op && (wr || rd) && addr > 16'h003F |=> err)
    else $error("port access above window accepted");
  chk_bit_range: assert property (
    bit_op != BIT_NONE && addr > 16'h001F |=> err)
    else $error("bit access above window accepted");
  chk_bit_taken: assert property (
    bit_op != BIT_NONE && bit_ok |=> !err)
    else $error("bit access in window refused");
endmodule

// ---- verification/testbench.sv ----
// testbench.sv: both ends joined, peripheral space modelled in the bench
// assumes 100 MHz clock and synchronous active-low reset
`timescale 1ns/1ns
module testbench import io_bridge_pkg::*;;
  logic        clock, rst_n, cmd_valid, cmd_ready, cmd_write, cmd_port;
  logic [15:0] cmd_addr, a;
  logic [1:0]  cmd_width, p_width;
  logic [31:0] cmd_wdata, cmd_resv, resp_rdata, p_live, p_wdata, cnt, d, r, v;
  bit_op_e     cmd_bit_op, o;
  logic [2:0]  cmd_bit_sel, b;
  logic        resp_valid, resp_skip, resp_err, p_wr;
  region_e     p_sel, p_wsel;
  logic [7:0]  p_off, p_woff;
  logic [3:0]  p_wbe;
  logic [31:0] pmem [0:2047];
  int          err_total, n_tests, n_commit, c0, j, seed;
  int unsigned exp_m [int];
  logic [15:0] bases [20] = '{16'h0000, 16'h0004, 16'h0008, 16'h001C,
    16'h0030, 16'h0040, 16'h0400, 16'h0420, 16'h0440, 16'h0820, 16'h08A0,
    16'h08C0, 16'h0A00, 16'h0A80, 16'h0A90, 16'h0F00, 16'h1000, 16'h1100,
    16'h1280, 16'h128A};
  logic [15:0] wa [5] = '{16'h0A08, 16'h0A24, 16'h0038, 16'h1028, 16'h0410};
  logic [7:0]  wo [5] = '{8'h08, 8'h24, 8'h08, 8'h28, 8'h10};
  logic [1:0]  ww [5] = '{2'h1, 2'h3, 2'h1, 2'h3, 2'h1};

  io_bus_if bus ();
  bus_master bus_master_inst (.clock(clock), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_width(cmd_width), .cmd_wdata(cmd_wdata),
    .cmd_resv(cmd_resv), .cmd_port(cmd_port), .cmd_bit_op(cmd_bit_op),
    .cmd_bit_sel(cmd_bit_sel), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .resp_skip(resp_skip), .resp_err(resp_err),
    .bus(bus));
  io_bridge io_bridge_inst (.clock(clock), .rst_n(rst_n), .bus(bus),
    .p_sel(p_sel), .p_off(p_off), .p_width(p_width), .p_live(p_live),
    .p_wr(p_wr), .p_wsel(p_wsel), .p_woff(p_woff), .p_wdata(p_wdata),
    .p_wbe(p_wbe));
  io_bus_props io_bus_props_inst (.clock(clock), .rst_n(rst_n),
    .addr(bus.addr), .wr(bus.wr), .rd(bus.rd), .port_op(bus.port_op),
    .bit_op(bus.bit_op), .rvalid(bus.rvalid), .skip(bus.skip),
    .err(bus.err));

  // offsets 0x08-0x1f hold 16-bit, 0x20-0x3f 32-bit registers
  assign p_width = p_off[5] ? 2'h3 : (p_off[4:3] != 2'h0 ? 2'h1 : 2'h0);
  // timer a offset 0x20 counts with equal bytes, so a torn read shows
  assign p_live = (p_sel == RG_TMA && p_off == 8'h20) ? cnt
                : pmem[{p_sel, p_off[5:0]}];

  // peripheral store: commits land bytewise
  always @(posedge clock) begin
    cnt <= rst_n ? {4{cnt[7:0] + 8'h01}} : 32'h0000_0000;
    if (rst_n && p_wr) begin
      n_commit++;
      for (int i = 0; i < 4; i++)
        if (p_wbe[i])
          pmem[{p_wsel, p_woff[5:0]}][8*i+:8] <= p_wdata[8*i+:8];
    end
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one host command, waits for its answer under a bounded count
  task automatic run(input logic w, input logic [15:0] ad,
                     input logic [1:0] wd, input logic [31:0] dt,
                     input logic [31:0] rv, input logic pt,
                     input bit_op_e op, input logic [2:0] bs);
    int k;
    while (cmd_ready !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    cmd_write   = w;
    cmd_addr    = ad;
    cmd_width   = wd;
    cmd_wdata   = dt;
    cmd_resv    = rv;
    cmd_port    = pt;
    cmd_bit_op  = op;
    cmd_bit_sel = bs;
    cmd_valid   = 1'b1;
    c0          = n_commit;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    k = 0;
    // an unmapped store answers in the very next cycle, so look first
    while (resp_valid !== 1'b1 && k < 30) begin
      @(posedge clock);
      #1;
      k++;
    end
    check({31'h0, resp_valid}, 32'h0000_0001);
  endtask

  // read back and compare with the model, trimmed to the width
  task automatic rdchk(input logic [15:0] ad, input logic [1:0] wd);
    logic [31:0] m;
    m = wd == 2'h0 ? 32'h0000_00FF
      : (wd == 2'h1 ? 32'h0000_FFFF : 32'hFFFF_FFFF);
    run(1'b0, ad, wd, 32'h0, 32'h0, 1'b0, BIT_NONE, 3'h0);
    check(resp_rdata & m, (exp_m.exists(ad) ? exp_m[ad] : 0) & m);
  endtask

  initial begin
    seed = 22898;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 16'h0000;
    cmd_width = 2'h0;
    cmd_wdata = 32'h0;
    cmd_resv = 32'h0;
    cmd_port = 1'b0;
    cmd_bit_op = BIT_NONE;
    cmd_bit_sel = 3'h0;
    for (int i = 0; i < 2048; i++)
      pmem[i] = 32'h0;
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    // every window base decodes to its own region
    for (int i = 0; i < 20; i++) begin
      d = $random(seed);
      run(1'b1, bases[i], 2'h0, d, 32'h0, 1'b0, BIT_NONE, 3'h0);
      check({27'h0, p_wsel}, i);
      check({24'h0, p_woff}, 32'h0);
      exp_m[bases[i]] = d & 32'h0000_00FF;
      rdchk(bases[i], 2'h0);
    end
    // wide registers: one commit per write, reserved bits cleared
    for (int n = 0; n < 10; n++) begin
      j = n % 5;
      d = $random(seed);
      r = $random(seed) & 32'h0101_0101;
      run(1'b1, wa[j], ww[j], d, r, 1'b0, BIT_NONE, 3'h0);
      check(n_commit - c0, 1);
      check({28'h0, p_wbe}, ww[j] == 2'h1 ? 32'h3 : 32'hF);
      check({24'h0, p_woff}, wo[j]);
      exp_m[wa[j]] = d & ~r;
      rdchk(wa[j], ww[j]);
    end
    // a running counter must come back with all bytes from one cycle
    repeat (4) begin
      run(1'b0, 16'h0A20, 2'h3, 32'h0, 32'h0, 1'b0, BIT_NONE, 3'h0);
      check(resp_rdata, {4{resp_rdata[7:0]}});
    end
    // every bit operation: set and skip-if-set on 0x0001, clear and skip-if-clear on 0x001D
    for (int q = 0; q < 16; q++) begin
      a = q[0] ? 16'h001D : 16'h0001;
      b = 3'($random(seed));
      o = bit_op_e'(q % 4 + 1);
      v = exp_m.exists(a) ? exp_m[a] : 0;
      run(1'b0, a, 2'h0, 32'h0, 32'h0, 1'b0, o, b);
      if (o == BIT_SET_INSTRUCTION)
        exp_m[a] = v | (32'h1 << b);
      if (o == BIT_CLEAR_INSTRUCTION)
        exp_m[a] = v & ~(32'h1 << b);
      if (o >= SKIP_IF_SET_INSTRUCTION)
        check({31'h0, resp_skip},
              v[b] ^ (o == SKIP_IF_CLEAR_INSTRUCTION));
      check({31'h0, resp_err}, 32'h0);
      rdchk(a, 2'h0);
    end
    // refused accesses: bit and port ops out of range, unmapped places; a port op at 0x0030 is taken
    run(1'b0, 16'h0400, 2'h0, 32'h0, 32'h0, 1'b0, BIT_CLEAR_INSTRUCTION, 3'h2);
    check({31'h0, resp_err}, 32'h1);
    run(1'b0, 16'h0400, 2'h0, 32'h0, 32'h0, 1'b1, BIT_NONE, 3'h0);
    check({31'h0, resp_err}, 32'h1);
    run(1'b1, 16'h0030, 2'h0, 32'h0000_00A5, 32'h0, 1'b1, BIT_NONE, 3'h0);
    run(1'b0, 16'h0030, 2'h0, 32'h0, 32'h0, 1'b1, BIT_NONE, 3'h0);
    check(resp_rdata & 32'h0000_00FF, 32'h0000_00A5);
    run(1'b1, 16'h1300, 2'h0, 32'h0000_005A, 32'h0, 1'b0, BIT_NONE, 3'h0);
    check({31'h0, resp_err}, 32'h1);
    check(n_commit - c0, 0);
    run(1'b0, 16'h2000, 2'h0, 32'h0, 32'h0, 1'b0, BIT_NONE, 3'h0);
    check({31'h0, resp_err}, 32'h1);
    check(resp_rdata, 32'h0);
    summarize();
  end

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    summarize();
  end
endmodule
